// File: rtl/scc_top.sv
`timescale 1ns/100ps
// Behaviour
// - CE low floats data, ignores inputs, clears test
// - Bits move on serial clock rising edges
// - Frequency output 1 Hz or 32.768 kHz
// - BCD counters, 24-hour, month-length rollover
// - Leap year from year tens/units digits
// - Bytes shifted least significant bit first
// - Counter ranges kept; don't-care bits ignored
// - Supply sampled every half second sets flag
// - Reads of 56+ edges clear supply flag
// - Frequency select resets to 1 Hz
// - First edge data low selects read
// - Snapshot at 8th falling edge, fixed order
// - Read output frozen after 60th edge
// - Host may end read early
// - Seconds carry never updates active snapshot
// - First edge data high selects write
// - Short writes discarded, extra bits ignored
// - Write halts counting, resets divider stages
module scc_top (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Serial link pins
  input wire scc_pkg::scc_pins_type pins_i,
  output logic data_o,
  output logic data_oe_o,
  // Supply detector and frequency output
  input wire logic supply_low_i,
  output logic freq_output_pin_o
);
  import scc_pkg::*;

  typedef struct packed {
    scc_pins_type sync1;
    scc_pins_type sync2;
    scc_pins_type prev;
    logic low1;
    logic low2;
    scc_state_type st;
    logic [6:0] edges;
    logic [SCC_FRAME_W-1:0] sr;
    logic hold;
    logic [31:0] acc;
    logic [15:0] pre;
    logic fast;
    scc_cal_type cal;
    logic [1:0][SCC_FRAME_W-1:0] fifo_d;
    logic [1:0] fifo_v;
    logic dout;
    logic doe;
    logic freq_out;
  } scc_state_all_type;

  scc_state_all_type s;
  scc_state_all_type next_s;

  // ==========================================================
  // Calendar helpers
  // Carry out in bit 8, wrapped value below it
  function automatic logic [8:0] bcd_inc(input logic [7:0] v, input logic [7:0] lo,
                                         input logic [7:0] hi);
    logic [7:0] r;
    r = v;
    if (v == hi) begin
      return {1'b1, lo};
    end
    if (v[3:0] == 4'h9) begin
      r = {v[7:4] + 4'h1, 4'h0};
    end else begin
      r = {v[7:4], v[3:0] + 4'h1};
    end
    return {1'b0, r};
  endfunction

  function automatic logic [7:0] month_days(input logic [7:0] mon, input logic [7:0] yr);
    logic leap;
    leap = (yr[4] && (yr[3:0] == 4'h2 || yr[3:0] == 4'h6))
        || (!yr[4] && (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8));
    case (mon)
      SCC_FEB: return leap ? SCC_DAYS_29 : SCC_DAYS_28;
      8'h04, 8'h06, 8'h09, 8'h11: return SCC_DAYS_30;
      default: return SCC_DAYS_31;
    endcase
  endfunction

  // ==========================================================
  // Next state
  always_comb begin
    logic ce, rise, fall, din, tick, half, pop, push_rdy, commit;
    logic [6:0] ne;
    logic [8:0] c_sec, c_min, c_hr, c_day, c_mon, c_yr, c_wk;
    logic [SCC_FRAME_W-1:0] snap, w;
    ce = 1'b0;
    rise = 1'b0;
    fall = 1'b0;
    din = 1'b0;
    tick = 1'b0;
    half = 1'b0;
    pop = 1'b0;
    push_rdy = 1'b0;
    commit = 1'b0;
    ne = 7'h00;
    c_sec = 9'h000;
    c_min = 9'h000;
    c_hr = 9'h000;
    c_day = 9'h000;
    c_mon = 9'h000;
    c_yr = 9'h000;
    c_wk = 9'h000;
    snap = '0;
    w = '0;
    next_s = s;

    // Pins pass two flops; the first is read only by the second
    next_s.sync1 = pins_i;
    next_s.sync2 = s.sync1;
    next_s.prev = s.sync2;
    next_s.low1 = supply_low_i;
    next_s.low2 = s.low1;
    ce = s.sync2.chip_enable;
    rise = ce && s.sync2.serial_clk && !s.prev.serial_clk;
    fall = ce && !s.sync2.serial_clk && s.prev.serial_clk;
    din = s.sync2.data;
    // Edge count saturates so long bursts never wrap
    ne = (s.edges == SCC_EDGE_MAX) ? s.edges : s.edges + 7'h01;

    // ==========================================================
    // Time base: 65536 Hz steps from the core clock
    // No second clock; the fast output carries one core cycle of jitter
    {next_s.fast, next_s.acc} = {1'b0, s.acc} + {1'b0, SCC_NCO_INC};
    if (s.fast) begin
      next_s.freq_out = s.cal.freq_select_bit ? ~s.freq_out : ~s.pre[15];
      tick = (s.pre == SCC_PRE_WRAP) && !s.hold;
      half = (s.pre[14:0] == SCC_HALF_SEC);
      next_s.pre = s.pre + 16'h0001;
    end
    if (!s.cal.freq_select_bit) begin
      next_s.freq_out = ~s.pre[15];
    end
    // Divider stages stay cleared while a write holds counting
    if (s.hold) begin
      next_s.pre = 16'h0000;
    end

    // ==========================================================
    // Calendar advance
    if (tick) begin
      c_sec = bcd_inc(s.cal.sec, SCC_ZERO, SCC_SEC_MAX);
      c_min = bcd_inc(s.cal.min, SCC_ZERO, SCC_MIN_MAX);
      c_hr = bcd_inc(s.cal.hr, SCC_ZERO, SCC_HR_MAX);
      c_wk = bcd_inc({5'h00, s.cal.wk}, SCC_WK_MIN, SCC_WK_MAX);
      c_day = bcd_inc(s.cal.day, SCC_DAY_MIN, month_days(s.cal.mon, s.cal.yr));
      c_mon = bcd_inc(s.cal.mon, SCC_MON_MIN, SCC_MON_MAX);
      c_yr = bcd_inc(s.cal.yr, SCC_ZERO, SCC_YR_MAX);
      next_s.cal.sec = c_sec[7:0];
      if (c_sec[8]) begin
        next_s.cal.min = c_min[7:0];
        if (c_min[8]) begin
          next_s.cal.hr = c_hr[7:0];
          if (c_hr[8]) begin
            next_s.cal.wk = c_wk[2:0];
            next_s.cal.day = c_day[7:0];
            if (c_day[8]) begin
              next_s.cal.mon = c_mon[7:0];
              if (c_mon[8]) begin
                next_s.cal.yr = c_yr[7:0];
              end
            end
          end
        end
      end
    end

    // ==========================================================
    // Two-entry commit buffer; drains only between seconds ticks
    // A carry and a commit never land in the same cycle
    pop = s.fifo_v[0] && !tick;
    push_rdy = !s.fifo_v[1] || pop;
    if (pop) begin
      w = s.fifo_d[0];
      next_s.cal.sec = {1'b0, w[SCC_POS_SEC+:7]};
      next_s.cal.min = {1'b0, w[SCC_POS_MIN+:7]};
      next_s.cal.hr = {2'b00, w[SCC_POS_HR+:6]};
      next_s.cal.wk = w[SCC_POS_WK+:3];
      next_s.cal.freq_select_bit = w[SCC_POS_FREQ_SEL];
      next_s.cal.day = {2'b00, w[SCC_POS_DAY+:6]};
      next_s.cal.mon = {3'b000, w[SCC_POS_MON+:5]};
      next_s.cal.factory_test_bit = w[SCC_POS_TEST];
      next_s.cal.yr = w[SCC_POS_YR+:8];
      next_s.fifo_d[0] = s.fifo_d[1];
      next_s.fifo_v = {1'b0, s.fifo_v[1]};
    end

    // ==========================================================
    // Serial session
    case (s.st)
      SCC_ST_IDLE: begin
        if (rise) begin
          next_s.edges = ne;
          next_s.st = din ? SCC_ST_WRITE : SCC_ST_READ;
        end
      end
      SCC_ST_READ: begin
        if (fall && s.edges == SCC_EDGE_LOAD) begin
          // Snapshot is fixed for the session; later carries lag by one second
          snap[SCC_POS_SEC+:8] = {s.cal.supply_low_flag, s.cal.sec[6:0]};
          snap[SCC_POS_MIN+:8] = s.cal.min;
          snap[SCC_POS_HR+:8] = s.cal.hr;
          snap[SCC_POS_WK+:4] = {s.cal.freq_select_bit, s.cal.wk};
          snap[SCC_POS_DAY+:8] = s.cal.day;
          snap[SCC_POS_MON+:8] = {s.cal.factory_test_bit, 2'b00, s.cal.mon[4:0]};
          snap[SCC_POS_YR+:8] = s.cal.yr;
          next_s.sr = snap;
        end
        if (rise) begin
          next_s.edges = ne;
          if (ne >= SCC_EDGE_FIRST && ne <= SCC_EDGE_LAST) begin
            next_s.dout = s.sr[0];
            next_s.doe = 1'b1;
            next_s.sr = {1'b0, s.sr[SCC_FRAME_W-1:1]};
          end
          // Past the last edge the line simply holds its value
        end
      end
      SCC_ST_WRITE: begin
        if (fall && s.edges == SCC_EDGE_MODE) begin
          next_s.hold = 1'b1;
        end
        if (rise) begin
          next_s.edges = ne;
          if (ne >= SCC_EDGE_FIRST && ne <= SCC_EDGE_LAST) begin
            next_s.sr = {din, s.sr[SCC_FRAME_W-1:1]};
          end
          // Word is taken whole at the last edge; short sessions commit no word
          commit = (ne == SCC_EDGE_LAST) && (s.edges != SCC_EDGE_LAST);
        end
      end
      default: begin
        next_s.st = SCC_ST_IDLE;
      end
    endcase

    // Full commit word is queued; a stalled buffer would drop it
    if (commit && push_rdy) begin
      if (next_s.fifo_v[0]) begin
        next_s.fifo_d[1] = {din, s.sr[SCC_FRAME_W-1:1]};
        next_s.fifo_v[1] = 1'b1;
      end else begin
        next_s.fifo_d[0] = {din, s.sr[SCC_FRAME_W-1:1]};
        next_s.fifo_v[0] = 1'b1;
      end
    end

    // ==========================================================
    // Chip enable low ends any session
    // A read cut short has sent only the bits already clocked
    // Recovery time between sessions is left to the host
    if (!ce) begin
      if (s.st == SCC_ST_READ && s.edges >= SCC_EDGE_CLR) begin
        next_s.cal.supply_low_flag = 1'b0;
      end
      next_s.st = SCC_ST_IDLE;
      next_s.edges = 7'h00;
      next_s.doe = 1'b0;
      next_s.hold = 1'b0;
      if (!pop) begin
        next_s.cal.factory_test_bit = 1'b0;
      end else begin
        next_s.cal.factory_test_bit = 1'b0;
      end
    end

    // Detector sample wins over a clear in the same cycle
    if (half && s.low2) begin
      next_s.cal.supply_low_flag = 1'b1;
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      s <= '0;
      s.st <= SCC_ST_IDLE;
      s.cal <= SCC_CAL_RESET;
      // Starts high, as the prescaler at zero gives; no false edge
      s.freq_out <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign data_o = s.dout;
  assign data_oe_o = s.doe;
  assign freq_output_pin_o = s.freq_out;

endmodule

// File: rtl/scc_pkg.sv
package scc_pkg;

  // ==========================================================
  // Clocking and time base
  localparam longint SCC_CLK_HZ = 64'd25000000;
  localparam longint SCC_XTAL_HZ = 64'd32768;
  // Accumulator steps at twice the crystal rate, one step per half cycle
  localparam logic [31:0] SCC_NCO_INC = 32'(((SCC_XTAL_HZ * 64'd2) << 32) / SCC_CLK_HZ);
  localparam logic [15:0] SCC_PRE_WRAP = 16'hFFFF;
  // Half second of the 65536 Hz prescaler
  localparam logic [14:0] SCC_HALF_SEC = 15'h0000;

  // ==========================================================
  // Serial session framing
  localparam logic [6:0] SCC_EDGE_MODE = 7'h01;
  localparam logic [6:0] SCC_EDGE_LOAD = 7'h08;
  localparam logic [6:0] SCC_EDGE_FIRST = 7'h09;
  localparam logic [6:0] SCC_EDGE_LAST = 7'h3C;
  localparam logic [6:0] SCC_EDGE_CLR = 7'h38;
  localparam logic [6:0] SCC_EDGE_MAX = 7'h7F;
  localparam int SCC_FRAME_W = 52;

  // ==========================================================
  // Field positions in the serial frame, LSB first
  localparam int SCC_POS_SEC = 0;
  localparam int SCC_POS_MIN = 8;
  localparam int SCC_POS_HR = 16;
  localparam int SCC_POS_WK = 24;
  localparam int SCC_POS_FREQ_SEL = 27;
  localparam int SCC_POS_DAY = 28;
  localparam int SCC_POS_MON = 36;
  localparam int SCC_POS_TEST = 43;
  localparam int SCC_POS_YR = 44;

  // ==========================================================
  // Calendar limits, BCD
  localparam logic [7:0] SCC_SEC_MAX = 8'h59;
  localparam logic [7:0] SCC_MIN_MAX = 8'h59;
  localparam logic [7:0] SCC_HR_MAX = 8'h23;
  localparam logic [7:0] SCC_WK_MIN = 8'h01;
  localparam logic [7:0] SCC_WK_MAX = 8'h07;
  localparam logic [7:0] SCC_DAY_MIN = 8'h01;
  localparam logic [7:0] SCC_MON_MIN = 8'h01;
  localparam logic [7:0] SCC_MON_MAX = 8'h12;
  localparam logic [7:0] SCC_YR_MAX = 8'h99;
  localparam logic [7:0] SCC_ZERO = 8'h00;
  localparam logic [7:0] SCC_FEB = 8'h02;
  localparam logic [7:0] SCC_DAYS_31 = 8'h31;
  localparam logic [7:0] SCC_DAYS_30 = 8'h30;
  localparam logic [7:0] SCC_DAYS_29 = 8'h29;
  localparam logic [7:0] SCC_DAYS_28 = 8'h28;

  // ==========================================================
  // Types
  typedef struct packed {
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hr;
    logic [2:0] wk;
    logic freq_select_bit;
    logic [7:0] day;
    logic [7:0] mon;
    logic factory_test_bit;
    logic [7:0] yr;
    logic supply_low_flag;
  } scc_cal_type;

  localparam scc_cal_type SCC_CAL_RESET = '{
    sec: 8'h00, min: 8'h00, hr: 8'h00, wk: 3'h1, freq_select_bit: 1'b0,
    day: 8'h01, mon: 8'h01, factory_test_bit: 1'b0, yr: 8'h00,
    supply_low_flag: 1'b0};

  typedef enum logic [2:0] {
    SCC_ST_IDLE = 3'b001,
    SCC_ST_READ = 3'b010,
    SCC_ST_WRITE = 3'b100
  } scc_state_type;

  // Pin group seen at the serial link
  typedef struct packed {
    logic chip_enable;
    logic serial_clk;
    logic data;
  } scc_pins_type;

endpackage

// File: tb/scc_checker.sv
`timescale 1ns/100ps
// =====
// Link checker
module scc_checker (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Pins and outputs
  input wire scc_pkg::scc_pins_type pins_i,
  input wire logic data_o,
  input wire logic data_oe_o,
  input wire logic supply_low_i,
  input wire logic freq_output_pin_o
);
  import scc_pkg::*;
  logic sck_d;
  logic oe_d;
  logic wr_mode;
  logic ce;
  logic rise;
  logic [6:0] nrise;
  logic [7:0] age;
  assign ce = pins_i.chip_enable;
  assign rise = pins_i.serial_clk && !sck_d;
  // Raw pin view, ahead of the design's sync flops
  always_ff @(posedge core_clk_i) begin
    sck_d <= pins_i.serial_clk;
    oe_d <= data_oe_o;
    if (rst_i || rise) begin
      age <= 8'h00;
    end else if (age != 8'hFF) begin
      age <= age + 8'h01;
    end
    if (rst_i || !ce) begin
      nrise <= 7'h00;
    end else if (rise && nrise != 7'h7F) begin
      nrise <= nrise + 7'h01;
    end
    if (rise && nrise == 7'h00) begin
      wr_mode <= pins_i.data;
    end
  end
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);
  sequence s_ce_idle;
    !ce [*6];
  endsequence
  sequence s_drive_start;
    !data_oe_o ##1 data_oe_o;
  endsequence
  a_idle_float: assert property (s_ce_idle |-> !data_oe_o)
    else $error("drive while idle");
  a_reset_quiet: assert property (disable iff (1'b0) rst_i |=> !data_oe_o && !data_o)
    else $error("drive in reset");
  a_bit_on_rise: assert property ($changed(data_o) && data_oe_o && oe_d |-> age < 8'h08)
    else $error("bit off rising edge");
  a_drive_start: assert property (s_drive_start |-> !wr_mode && nrise > 7'h08)
    else $error("early drive");
  a_silent_header: assert property (ce && nrise < 7'h09 |-> !data_oe_o)
    else $error("drive in header");
  a_write_listen: assert property (ce && wr_mode && nrise > 7'h01 |-> !data_oe_o)
    else $error("drive in write");
  a_frozen_tail: assert property (ce && nrise > 7'h3C |-> $stable(data_o))
    else $error("data moved after 60");
  a_freq_reset: assert property ($fell(rst_i) |-> $stable(freq_output_pin_o) [*8])
    else $error("frequency output moved after reset");
endmodule

// File: tb/scc_host.sv
`timescale 1ns/100ps
// =====
// Host side of the link
module scc_host (
  // Clock
  input wire logic core_clk_i,
  // Device pin drive
  input wire logic dev_data_i,
  input wire logic dev_oe_i,
  // Link pins
  output scc_pkg::scc_pins_type pins_o
);
  import scc_pkg::*;
  logic ce = 1'b0;
  logic sck = 1'b0;
  logic hd = 1'b0;
  logic hoe = 1'b0;
  logic last = 1'b0;
  // No pull on the wire: released, it shows the inverse of its last level
  assign pins_o = '{chip_enable: ce, serial_clk: sck,
    data: dev_oe_i ? dev_data_i : hoe ? hd : ~last};
  always_ff @(posedge core_clk_i) begin
    if (dev_oe_i || hoe) begin
      last <= pins_o.data;
    end
  end
  task automatic session(input logic wr, input int n, input logic [51:0] wd,
                         output logic [51:0] rd);
    rd = '0;
    ce <= 1'b1;
    repeat (6) @(posedge core_clk_i);
    for (int k = 1; k <= n; k++) begin
      hoe <= wr || k == 1;
      hd <= k == 1 ? wr : k > 60 || (k > 8 && wd[k-9]);
      repeat (6) @(posedge core_clk_i);
      sck <= 1'b1;
      repeat (6) @(posedge core_clk_i);
      if (!wr && k > 8 && k < 61) begin
        rd[k-9] = pins_o.data;
      end
      sck <= 1'b0;
    end
    repeat (6) @(posedge core_clk_i);
    ce <= 1'b0;
    hoe <= 1'b0;
    // Wait sized for the slower supply
    repeat (50) @(posedge core_clk_i);
  endtask
endmodule

// File: tb/scc_top_bench.sv
`timescale 1ns/100ps
// =====
// Bench top
module scc_top_bench;
  import scc_pkg::*;
  logic core_clk_i;
  logic rst_i = 1'b1;
  logic supply_low_i = 1'b0;
  logic data_o;
  logic data_oe_o;
  logic freq_output_pin_o;
  scc_pins_type pins;
  int mismatches = 0;
  int checks = 0;
  int cnt;
  logic [51:0] rd;
  // Ones in every ignored bit; test bit kept 0
  localparam logic [51:0] RAW_A = {8'h96, 8'h71, 8'hE8, 4'h5, 8'hE1, 8'hB7, 8'hC5};
  localparam logic [51:0] EXP_A = {8'h96, 8'h11, 8'h28, 4'h5, 8'h21, 8'h37, 8'h45};
  localparam logic [51:0] EXP_B = {8'h00, 8'h12, 8'h31, 4'h7, 8'h23, 8'h59, 8'h59};
  scc_top u_dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .pins_i(pins), .data_o(data_o),
    .data_oe_o(data_oe_o), .supply_low_i(supply_low_i),
    .freq_output_pin_o(freq_output_pin_o));
  scc_host u_host (.core_clk_i(core_clk_i), .dev_data_i(data_o), .dev_oe_i(data_oe_o),
    .pins_o(pins));
  initial begin
    core_clk_i = 1'b0;
    forever #20 core_clk_i = ~core_clk_i;
  end
  task automatic check(input logic [51:0] got, input logic [51:0] want);
    checks++;
    if (got !== want) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, got, want);
    end
  endtask
  task automatic rises(input int n);
    logic prev;
    cnt = 0;
    prev = freq_output_pin_o;
    repeat (n) begin
      @(posedge core_clk_i);
      if (freq_output_pin_o === 1'b1 && prev === 1'b0) begin
        cnt++;
      end
      prev = freq_output_pin_o;
    end
  endtask
  task automatic t_freq_idle();
    rises(800);
    check(52'(cnt), 52'h0);
    $display("freq idle done");
  endtask
  task automatic t_round_trip();
    u_host.session(1'b1, 60, RAW_A, rd);
    u_host.session(1'b0, 60, '0, rd);
    check(rd, EXP_A);
    $display("round trip done");
  endtask
  task automatic t_write_limits();
    u_host.session(1'b1, 64, EXP_B, rd);
    u_host.session(1'b1, 59, RAW_A, rd);
    u_host.session(1'b0, 60, '0, rd);
    check(rd, EXP_B);
    $display("write limits done");
  endtask
  task automatic t_partial_read();
    u_host.session(1'b0, 36, '0, rd);
    check(rd, {24'h0, EXP_B[27:0]});
    u_host.session(1'b0, 64, '0, rd);
    check(rd, EXP_B);
    $display("partial read done");
  endtask
  task automatic t_supply_flag();
    supply_low_i <= 1'b1;
    u_host.session(1'b1, 60, RAW_A, rd);
    supply_low_i <= 1'b0;
    u_host.session(1'b0, 55, '0, rd);
    check(52'(rd[7:0]), 52'hC5);
    u_host.session(1'b0, 56, '0, rd);
    check(52'(rd[7:0]), 52'hC5);
    u_host.session(1'b0, 60, '0, rd);
    check(rd, EXP_A);
    $display("supply flag done");
  endtask
  task automatic t_freq_fast();
    u_host.session(1'b1, 60, EXP_B | 52'h8000000, rd);
    repeat (763) @(posedge core_clk_i);
    rises(7630);
    check(52'(cnt >= 9 && cnt <= 11), 52'h1);
    $display("freq fast done");
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge core_clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge core_clk_i);
    t_freq_idle();
    t_round_trip();
    t_write_limits();
    t_partial_read();
    t_supply_flag();
    t_freq_fast();
    results();
  end
  // About 20k cycles expected
  initial begin
    repeat (60000) @(posedge core_clk_i);
    mismatches++;
    $display("watchdog expired");
    results();
  end
endmodule
bind scc_top scc_checker u_chk (.core_clk_i(core_clk_i), .rst_i(rst_i), .pins_i(pins_i),
  .data_o(data_o), .data_oe_o(data_oe_o), .supply_low_i(supply_low_i),
  .freq_output_pin_o(freq_output_pin_o));
